// ==== src/tmlc_top.sv ====
// Contract
// RQ1: stored triggered current reaches the output only on a trigger command.
// RQ2: triggered current above model maximum posts error code -222.
// RQ3: triggered current query returns the last stored value.
// RQ4: regulation select accepts voltage, current and external modes.
// RQ5: in voltage mode, current-limit overrun raises the error flag.
// RQ6: in current mode, voltage-limit overrun raises the error flag.
// RQ7: regulation query reads 0 for voltage, 1 for current.
// RQ8: trigger switches regulation to the stored pending mode.
// RQ9: pending mode query reads 0 for voltage, 1 for current.
// RQ10: list clear returns every list pointer to 0.
// RQ11: list clear releases list control of the output-off flag.
// RQ12: repeat count accepts integers 0 to 255.
// RQ13: repeat count 0 runs the list until fixed mode is commanded.
// RQ14: repeat count query returns the last stored count.
// RQ15: list clear empties level and dwell tables, restarting at location 0.
// RQ16: level tally equals the index of the next location written.
// RQ17: after list clear the query start pointer reads 0.
// RQ18: successive level writes append at the next free location.
// RQ19: a lone first dwell entry applies to every list location.
// RQ20: list clear resets the leading step skip count to 0.
// RQ21: a rejected triggered current write keeps the old value.
`timescale 1ns/1ps
module tmlc_top #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter logic [31:0] CURR_MAX = 32'h00010000
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // analog monitor flags
    input wire logic i_over_current,
    input wire logic i_over_voltage,
    // output side
    output logic [31:0] o_current_level,
    output tmlc_pkg::tmlc_mode_t o_regulation,
    output logic o_limit_error,
    output logic o_list_output_off
);
    import tmlc_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [31:0] trig_curr_r;
    logic [31:0] out_curr_r;
    tmlc_mode_t mode_r;
    logic pending_r;
    logic [7:0] repeat_r;
    logic [7:0] skip_r;
    logic [AW:0] qstart_r;
    logic [AW:0] level_ptr_r;
    logic [AW:0] dwell_ptr_r;
    logic [31:0] level_mem [DEPTH];
    logic [31:0] dwell_mem [DEPTH];
    logic limit_err_r;
    logic range_err_r;
    logic [31:0] errcode_r;
    logic list_run_r;
    logic list_off_ctl_r;
    logic [31:0] rdata_r;
    // address phase capture
    logic wr_pend_r;
    logic [7:0] waddr_r;
    logic wr_go;
    logic rd_go;
    logic [31:0] cmd;

    // full-word sizes only; anything else is simply stored anyway
    assign rd_go = i_hsel && i_hready && (i_htrans == TMLC_HTRANS_NONSEQ) && !i_hwrite;
    assign cmd = (wr_pend_r && waddr_r == TMLC_OFS_COMMAND) ? i_hwdata : 32'h00000000;
    assign wr_go = wr_pend_r;

    // ---------------------------------------------------------------
    // bus slave: zero wait states, always OKAY
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wr_pend_r <= 1'b0;
            waddr_r <= 8'h00;
        end else begin
            wr_pend_r <= i_hsel && i_hready && (i_htrans == TMLC_HTRANS_NONSEQ) && i_hwrite;
            waddr_r <= i_haddr;
        end
    end

    // dwell read: a lone entry 0 covers all locations
    function automatic logic [31:0] dwell_at(input logic [AW:0] idx);
        if (dwell_ptr_r == (AW+1)'(1))
            return dwell_mem[0]; // RQ19
        else
            return dwell_mem[idx[AW-1:0]];
    endfunction

    // read mux, registered so hrdata comes from a flop
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rdata_r <= 32'h00000000;
        end else if (rd_go) begin
            case (i_haddr)
                TMLC_OFS_TRIG_CURR: rdata_r <= trig_curr_r; // RQ3
                TMLC_OFS_REGULATION: rdata_r <= {30'h0, mode_r}; // RQ7
                TMLC_OFS_PENDING: rdata_r <= {31'h0, pending_r}; // RQ9
                TMLC_OFS_REPEAT: rdata_r <= {24'h0, repeat_r}; // RQ14
                TMLC_OFS_SKIP: rdata_r <= {24'h0, skip_r};
                TMLC_OFS_QSTART: rdata_r <= 32'(qstart_r); // RQ17
                TMLC_OFS_LEVEL: rdata_r <= level_mem[qstart_r[AW-1:0]];
                TMLC_OFS_DWELL_RD: rdata_r <= dwell_at(qstart_r);
                TMLC_OFS_TALLY: rdata_r <= 32'(level_ptr_r); // RQ16
                TMLC_OFS_DTALLY: rdata_r <= 32'(dwell_ptr_r);
                TMLC_OFS_STATUS: rdata_r <= {27'h0, repeat_r == 8'h00, list_off_ctl_r,
                    list_run_r, range_err_r, limit_err_r};
                TMLC_OFS_OUTPUT: rdata_r <= out_curr_r;
                TMLC_OFS_ERRCODE: rdata_r <= errcode_r;
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // triggered current and output transfer
    // ---------------------------------------------------------------
    // a write never touches the output; only the trigger moves it
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            trig_curr_r <= 32'h00000000;
            out_curr_r <= 32'h00000000;
        end else begin
            if (wr_go && waddr_r == TMLC_OFS_TRIG_CURR && i_hwdata <= CURR_MAX)
                trig_curr_r <= i_hwdata; // RQ21
            if (cmd[TMLC_CMD_TRIGGER])
                out_curr_r <= trig_curr_r; // RQ1
        end
    end

    // out-of-range write posts -222; set wins over a same-cycle clear
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            range_err_r <= 1'b0;
            errcode_r <= TMLC_ERR_NONE;
        end else if (wr_go && waddr_r == TMLC_OFS_TRIG_CURR && i_hwdata > CURR_MAX) begin
            range_err_r <= 1'b1; // RQ2
            errcode_r <= TMLC_ERR_RANGE; // RQ2
        end else if (cmd[TMLC_CMD_ERRCLR]) begin
            range_err_r <= 1'b0;
            errcode_r <= TMLC_ERR_NONE;
        end
    end

    // ---------------------------------------------------------------
    // regulation modes
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            mode_r <= TMLC_MODE_CV;
            pending_r <= 1'b0;
        end else begin
            if (wr_go && waddr_r == TMLC_OFS_PENDING)
                pending_r <= i_hwdata[0];
            if (cmd[TMLC_CMD_TRIGGER])
                mode_r <= pending_r ? TMLC_MODE_CC : TMLC_MODE_CV; // RQ8
            else if (wr_go && waddr_r == TMLC_OFS_REGULATION) begin
                case (i_hwdata[1:0])
                    2'h0: mode_r <= TMLC_MODE_CV; // RQ4
                    2'h1: mode_r <= TMLC_MODE_CC; // RQ4
                    2'h2: mode_r <= TMLC_MODE_EXT; // RQ4
                    default: mode_r <= mode_r;
                endcase
            end
        end
    end

    // monitored quantity follows commanded mode; sticky, set beats clear
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            limit_err_r <= 1'b0;
        end else if ((mode_r == TMLC_MODE_CV && i_over_current) ||
                     (mode_r == TMLC_MODE_CC && i_over_voltage)) begin
            limit_err_r <= 1'b1; // RQ5 RQ6
        end else if (cmd[TMLC_CMD_ERRCLR]) begin
            limit_err_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // list sequencer control
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            repeat_r <= 8'h00;
            skip_r <= 8'h00;
            qstart_r <= '0;
        end else if (cmd[TMLC_CMD_CLEAR]) begin
            skip_r <= 8'h00; // RQ20
            qstart_r <= '0; // RQ10 RQ17
        end else if (wr_go) begin
            // values above 255 are cut to the 8-bit field
            if (waddr_r == TMLC_OFS_REPEAT)
                repeat_r <= i_hwdata[7:0]; // RQ12
            if (waddr_r == TMLC_OFS_SKIP)
                skip_r <= i_hwdata[7:0];
            if (waddr_r == TMLC_OFS_QSTART)
                qstart_r <= i_hwdata[AW:0];
        end
    end

    // append pointers; full table ignores further entries
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            level_ptr_r <= '0;
            dwell_ptr_r <= '0;
        end else if (cmd[TMLC_CMD_CLEAR]) begin
            level_ptr_r <= '0; // RQ10 RQ15
            dwell_ptr_r <= '0; // RQ15
        end else if (wr_go) begin
            if (waddr_r == TMLC_OFS_LEVEL && level_ptr_r < (AW+1)'(DEPTH))
                level_ptr_r <= level_ptr_r + (AW+1)'(1); // RQ18
            if (waddr_r == TMLC_OFS_DWELL && dwell_ptr_r < (AW+1)'(DEPTH))
                dwell_ptr_r <= dwell_ptr_r + (AW+1)'(1);
        end
    end

    // table storage, no reset needed: pointers define contents
    always_ff @(posedge i_sys_clk) begin
        if (wr_go && waddr_r == TMLC_OFS_LEVEL && level_ptr_r < (AW+1)'(DEPTH))
            level_mem[level_ptr_r[AW-1:0]] <= i_hwdata; // RQ18
        if (wr_go && waddr_r == TMLC_OFS_DWELL && dwell_ptr_r < (AW+1)'(DEPTH))
            dwell_mem[dwell_ptr_r[AW-1:0]] <= i_hwdata;
    end

    // run flag: any count keeps it running until fixed mode or list clear
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            list_run_r <= 1'b0;
            list_off_ctl_r <= 1'b0;
        end else begin
            if (cmd[TMLC_CMD_FIXED] || cmd[TMLC_CMD_CLEAR])
                list_run_r <= 1'b0; // RQ13
            else if (cmd[TMLC_CMD_LIST])
                list_run_r <= 1'b1;
            if (cmd[TMLC_CMD_CLEAR])
                list_off_ctl_r <= 1'b0; // RQ11
            else if (cmd[TMLC_CMD_LIST])
                list_off_ctl_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end
    assign o_hrdata = rdata_r;
    assign o_current_level = out_curr_r;
    assign o_regulation = mode_r;
    assign o_limit_error = limit_err_r;
    assign o_list_output_off = list_off_ctl_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_trig_wr;
        wr_go && waddr_r == TMLC_OFS_TRIG_CURR;
    endsequence
    chk_trig_transfer: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ1
        cmd[TMLC_CMD_TRIGGER] |=> out_curr_r == $past(trig_curr_r))
        else $error("output did not take triggered value");
    chk_no_early_out: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ1
        !cmd[TMLC_CMD_TRIGGER] |=> $stable(out_curr_r))
        else $error("output moved without trigger");
    chk_range_error: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ2
        s_trig_wr and (i_hwdata > CURR_MAX) |=> errcode_r == TMLC_ERR_RANGE && range_err_r)
        else $error("range error not posted");
    chk_reject_keep: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ21
        s_trig_wr and (i_hwdata > CURR_MAX) |=> $stable(trig_curr_r))
        else $error("rejected value was stored");
    chk_cv_monitor: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ5
        mode_r == TMLC_MODE_CV && i_over_current |=> limit_err_r)
        else $error("current overrun not flagged");
    chk_cc_monitor: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ6
        mode_r == TMLC_MODE_CC && i_over_voltage |=> limit_err_r)
        else $error("voltage overrun not flagged");
    chk_trig_mode: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ8
        cmd[TMLC_CMD_TRIGGER] |=> mode_r == ($past(pending_r) ? TMLC_MODE_CC : TMLC_MODE_CV))
        else $error("trigger mode not applied");
    chk_clear_ptrs: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ10
        cmd[TMLC_CMD_CLEAR] |=> level_ptr_r == '0 && dwell_ptr_r == '0 && qstart_r == '0
            && skip_r == 8'h00 && !list_off_ctl_r)
        else $error("list clear incomplete");
    chk_append: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ18
        wr_go && waddr_r == TMLC_OFS_LEVEL && !cmd[TMLC_CMD_CLEAR]
            && level_ptr_r < (AW+1)'(DEPTH) |=> level_ptr_r == $past(level_ptr_r) + 1'b1)
        else $error("level pointer did not advance");
    chk_forever: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ13
        list_run_r && !cmd[TMLC_CMD_FIXED] && !cmd[TMLC_CMD_CLEAR] |=> list_run_r)
        else $error("list stopped without fixed command");
    // stored settings move only on their own writes, trigger (mode) or list clear (tally)
    sequence s_level_wr;
        wr_go && waddr_r == TMLC_OFS_LEVEL;
    endsequence
    chk_accept_store: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ3
        s_trig_wr and (i_hwdata <= CURR_MAX) |=> trig_curr_r == $past(i_hwdata))
        else $error("accepted value not stored");
    chk_trig_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ3
        !(wr_go && waddr_r == TMLC_OFS_TRIG_CURR) |=> $stable(trig_curr_r))
        else $error("stored value changed without write");
    chk_mode_select: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ4
        wr_go && waddr_r == TMLC_OFS_REGULATION && i_hwdata[1:0] != 2'h3
            |=> mode_r == $past(i_hwdata[1:0]))
        else $error("regulation select not applied");
    // external mode watches neither monitor flag
    chk_ext_quiet: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ4
        mode_r == TMLC_MODE_EXT && !limit_err_r |=> !limit_err_r)
        else $error("limit error raised in external mode");
    chk_limit_sticky: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ5 RQ6
        limit_err_r && !cmd[TMLC_CMD_ERRCLR] |=> limit_err_r)
        else $error("limit error dropped without clear");
    chk_pending_store: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ9
        wr_go && waddr_r == TMLC_OFS_PENDING |=> pending_r == $past(i_hwdata[0]))
        else $error("pending mode not stored");
    chk_repeat_store: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ14
        wr_go && waddr_r == TMLC_OFS_REPEAT |=> repeat_r == $past(i_hwdata[7:0]))
        else $error("repeat count not stored");
    chk_tally_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ16
        !cmd[TMLC_CMD_CLEAR] && !(wr_go && waddr_r == TMLC_OFS_LEVEL)
            |=> $stable(level_ptr_r))
        else $error("level tally moved without append");
    chk_level_full: assert property (@(posedge i_sys_clk) disable iff (i_reset) // RQ18
        s_level_wr and (level_ptr_r == (AW+1)'(DEPTH)) |=> $stable(level_ptr_r))
        else $error("full level table still advanced");
endmodule // tmlc_top

// ==== src/tmlc_pkg.sv ====
package tmlc_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] TMLC_OFS_COMMAND = 8'h00;
    localparam logic [7:0] TMLC_OFS_TRIG_CURR = 8'h04;
    localparam logic [7:0] TMLC_OFS_REGULATION = 8'h08;
    localparam logic [7:0] TMLC_OFS_PENDING = 8'h0C;
    localparam logic [7:0] TMLC_OFS_REPEAT = 8'h10;
    localparam logic [7:0] TMLC_OFS_SKIP = 8'h14;
    localparam logic [7:0] TMLC_OFS_QSTART = 8'h18;
    localparam logic [7:0] TMLC_OFS_LEVEL = 8'h1C;
    localparam logic [7:0] TMLC_OFS_DWELL = 8'h20;
    localparam logic [7:0] TMLC_OFS_TALLY = 8'h24;
    localparam logic [7:0] TMLC_OFS_DTALLY = 8'h28;
    localparam logic [7:0] TMLC_OFS_STATUS = 8'h2C;
    localparam logic [7:0] TMLC_OFS_OUTPUT = 8'h30;
    localparam logic [7:0] TMLC_OFS_ERRCODE = 8'h34;
    localparam logic [7:0] TMLC_OFS_DWELL_RD = 8'h38;
    // ---------------------------------------------------------------
    // command register bits
    // ---------------------------------------------------------------
    localparam int TMLC_CMD_TRIGGER = 0;
    localparam int TMLC_CMD_CLEAR = 1;
    localparam int TMLC_CMD_FIXED = 2;
    localparam int TMLC_CMD_LIST = 3;
    localparam int TMLC_CMD_ERRCLR = 4;
    // ---------------------------------------------------------------
    // status bits
    // ---------------------------------------------------------------
    localparam int TMLC_ST_LIMIT_ERR = 0;
    localparam int TMLC_ST_RANGE_ERR = 1;
    localparam int TMLC_ST_LIST_RUN = 2;
    localparam int TMLC_ST_LIST_OFF = 3;
    localparam int TMLC_ST_FOREVER = 4;
    // error code -222 as two's complement
    localparam logic [31:0] TMLC_ERR_RANGE = 32'hFFFFFF22;
    localparam logic [31:0] TMLC_ERR_NONE = 32'h00000000;
    localparam logic [7:0] TMLC_REPEAT_MAX = 8'hFF;
    localparam logic [1:0] TMLC_HTRANS_NONSEQ = 2'h2;
    // regulation modes, query codes 0, 1 and 2
    typedef enum logic [1:0] {
        TMLC_MODE_CV = 2'h0,
        TMLC_MODE_CC = 2'h1,
        TMLC_MODE_EXT = 2'h2
    } tmlc_mode_t;
endpackage

// ==== tb/tmlc_host.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side: single-word bus master, one transfer at a time
// ----------------------------------------------------------------
module tmlc_host (
    // clock
    input wire logic i_sys_clk,
    // slave answer
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // master request
    output logic o_hsel,
    output logic [7:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    logic timed_out;
    // idle bus at time zero
    initial begin
        timed_out = 1'b0;
        o_hsel = 1'b0;
        o_haddr = 8'h00;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h00000000;
    end
    // bounded wait; a hung slave must not hang the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (i_hready !== 1'b1 && n < 16);
        if (i_hready !== 1'b1) timed_out = 1'b1;
    endtask
    // address phase held until hready seen high, then bus goes idle
    task automatic addr_phase(input logic [7:0] a, input logic w);
        @(posedge i_sys_clk);
        o_hsel <= 1'b1;
        o_haddr <= a;
        o_htrans <= tmlc_pkg::TMLC_HTRANS_NONSEQ;
        o_hwrite <= w;
        o_hsize <= 3'h2;
        wait_rdy();
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
    endtask
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        o_hwdata <= d;
        wait_rdy();
        o_hwdata <= ~d; // stale data must not look valid
    endtask
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        addr_phase(a, 1'b0);
        wait_rdy();
        d = i_hrdata;
    endtask
endmodule // tmlc_host

// ==== tb/trigger_mode_list_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module trigger_mode_list_control_tb;
    import tmlc_pkg::*;
    localparam logic [31:0] CMAX = 32'h00010000;
    logic clk;
    logic rst;
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic oc;
    logic ov;
    logic [31:0] level;
    tmlc_mode_t regul;
    logic lim_err;
    logic list_off;
    int error_cnt;
    int num_checks;
    // ----------------------------------------------------------------
    // clock, reset and instances
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    tmlc_top #(.CURR_MAX(CMAX)) dut (.i_sys_clk(clk), .i_reset(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_over_current(oc), .i_over_voltage(ov),
        .o_current_level(level), .o_regulation(regul), .o_limit_error(lim_err),
        .o_list_output_off(list_off));
    tmlc_host host (.i_sys_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));
    // ----------------------------------------------------------------
    // shared bus and timing helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // a timed-out transfer counts as a mismatch and ends the run
    task automatic to_chk();
        if (host.timed_out) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.write(a, d);
        to_chk();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        host.read(a, d);
        to_chk();
    endtask
    task automatic cmd(input int b);
        wr(TMLC_OFS_COMMAND, 32'h00000001 << b);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(v, e)
    endtask
    // monitor flags applied at an edge, sticky error judged later
    task automatic mon(input logic c, input logic vlt, input logic e);
        @(posedge clk);
        oc <= c;
        ov <= vlt;
        settle(3);
        `CHK(lim_err, e)
        @(posedge clk);
        oc <= 1'b0;
        ov <= 1'b0;
        cmd(TMLC_CMD_ERRCLR);
        settle(2);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        `CHK(hready, 1'b1)
        `CHK(level, 32'h00000000)
        `CHK(regul, TMLC_MODE_CV)
        `CHK(list_off, 1'b0)
        wr(8'hFC, 32'h0000005A); // unmapped write is dropped
        rd_chk(8'hFC, 32'h00000000);
        `CHK(hresp, 1'b0)
    endtask
    task automatic t_trigger();
        wr(TMLC_OFS_TRIG_CURR, 32'h00001234);
        settle(2);
        `CHK(level, 32'h00000000)
        rd_chk(TMLC_OFS_TRIG_CURR, 32'h00001234);
        wr(TMLC_OFS_TRIG_CURR, CMAX + 32'h1);
        rd_chk(TMLC_OFS_ERRCODE, TMLC_ERR_RANGE);
        // repeat count is still 0 here, so the run-forever bit stands too
        rd_chk(TMLC_OFS_STATUS, (32'h1 << TMLC_ST_RANGE_ERR) | (32'h1 << TMLC_ST_FOREVER));
        rd_chk(TMLC_OFS_TRIG_CURR, 32'h00001234);
        wr(TMLC_OFS_TRIG_CURR, CMAX);
        rd_chk(TMLC_OFS_TRIG_CURR, CMAX);
        wr(TMLC_OFS_PENDING, 32'h1);
        rd_chk(TMLC_OFS_PENDING, 32'h1);
        cmd(TMLC_CMD_TRIGGER);
        settle(2);
        `CHK(level, CMAX)
        `CHK(regul, TMLC_MODE_CC)
        rd_chk(TMLC_OFS_REGULATION, 32'h1);
        wr(TMLC_OFS_PENDING, 32'h0);
        rd_chk(TMLC_OFS_PENDING, 32'h0);
        cmd(TMLC_CMD_TRIGGER);
        settle(2);
        `CHK(regul, TMLC_MODE_CV)
        rd_chk(TMLC_OFS_REGULATION, 32'h0);
        cmd(TMLC_CMD_ERRCLR);
    endtask
    task automatic t_modes();
        for (int m = 2; m >= 0; m--) begin
            wr(TMLC_OFS_REGULATION, 32'(m));
            rd_chk(TMLC_OFS_REGULATION, 32'(m));
        end
        mon(1'b0, 1'b1, 1'b0);
        mon(1'b1, 1'b0, 1'b1);
        wr(TMLC_OFS_REGULATION, 32'h1);
        mon(1'b1, 1'b0, 1'b0);
        mon(1'b0, 1'b1, 1'b1);
        wr(TMLC_OFS_REGULATION, 32'h2);
        mon(1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_repeat();
        wr(TMLC_OFS_REPEAT, 32'h000000FF);
        rd_chk(TMLC_OFS_REPEAT, 32'h000000FF);
        wr(TMLC_OFS_REPEAT, 32'h0);
        rd_chk(TMLC_OFS_REPEAT, 32'h0);
        cmd(TMLC_CMD_LIST);
        settle(30);
        rd_chk(TMLC_OFS_STATUS, 32'h1C);
        cmd(TMLC_CMD_FIXED);
        rd_chk(TMLC_OFS_STATUS, 32'h18);
    endtask
    task automatic t_list();
        wr(TMLC_OFS_SKIP, 32'h3);
        for (int i = 0; i < 3; i++) wr(TMLC_OFS_LEVEL, 32'h100 + 32'(i));
        rd_chk(TMLC_OFS_TALLY, 32'h3);
        for (int i = 3; i < 5; i++) wr(TMLC_OFS_LEVEL, 32'h100 + 32'(i));
        rd_chk(TMLC_OFS_TALLY, 32'h5);
        wr(TMLC_OFS_QSTART, 32'h3);
        rd_chk(TMLC_OFS_LEVEL, 32'h103);
        wr(TMLC_OFS_DWELL, 32'h0000000A);
        rd_chk(TMLC_OFS_DWELL_RD, 32'h0000000A);
        // a second dwell entry ends the lone-entry fill
        wr(TMLC_OFS_DWELL, 32'h0000000B);
        wr(TMLC_OFS_QSTART, 32'h1);
        rd_chk(TMLC_OFS_DWELL_RD, 32'h0000000B);
        rd_chk(TMLC_OFS_LEVEL, 32'h101);
        cmd(TMLC_CMD_CLEAR);
        settle(2);
        `CHK(list_off, 1'b0)
        rd_chk(TMLC_OFS_TALLY, 32'h0);
        rd_chk(TMLC_OFS_DTALLY, 32'h0);
        rd_chk(TMLC_OFS_QSTART, 32'h0);
        rd_chk(TMLC_OFS_SKIP, 32'h0);
        wr(TMLC_OFS_LEVEL, 32'h55);
        rd_chk(TMLC_OFS_LEVEL, 32'h55);
    endtask
    // main sequence: reset for 8 cycles, then every scenario in turn
    initial begin
        error_cnt = 0;
        num_checks = 0;
        rst = 1'b1;
        oc = 1'b0;
        ov = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        t_reset();
        t_trigger();
        t_modes();
        t_repeat();
        t_list();
        end_of_test();
    end
endmodule // trigger_mode_list_control_tb
